/* hw/infrared_pulse_endec.sv */
// infrared pulse encoder/decoder between a UART and an infrared transceiver
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [R1] every bit is sixteen baud ticks
// [R2] transmit one: output low whole symbol
// [R3] transmit zero: 7 low, 3 high, 6 low
// [R4] half duplex, never transmit and receive together
// [R5] enabled: encoder output drives transmit pin
// [R6] enabled: decoder output feeds UART input
// [R7] timing from UART baud tick only
// [R8] works only while UART is enabled
// [R9] decoder tick counter runs 0 to 15
// [R10] decoded stream lags input by 8 ticks
// [R11] falling edge resets decoder counter; code ignores edges in RX_FIRST
// [R12] count 8 updates UART-facing output
// [R13] window open from 12 until next 8
// [R14] no pulse in window: back to idle
// [R15] resync never disturbs UART receive timing
// [R16] supports 9600 to 115200 baud and above
// [R17] system clock at least 1 MHz
// [R18] enable before selecting pin alternate function
// [R19] disabled: UART connects straight to pins
module infrared_pulse_endec
    import irda_endec_pkg::*;
(
    input  wire logic CLK_SYS_IN,               // 125 MHz system clock
    input  wire logic RESETN_IN,                // async reset, active low
    input  wire logic BAUD_TICK_IN,             // UART baud tick, 16 per bit
    input  wire logic UART_ENABLE_IN,           // UART enable
    input  wire logic INFRARED_ENDEC_ENABLE_IN, // endec enable
    input  wire logic UART_TXD_IN,              // UART serial output
    input  wire logic UART_TX_VALID_IN,         // UART tx bit presented
    output logic      UART_TX_READY_OUT,        // buffer accepts tx bit
    output logic      UART_RXD_OUT,             // serial input to UART
    output logic      TXD_PIN_OUT,              // transmit pin
    input  wire logic INFRARED_PULSE_IN         // receive pin
);
    logic       rx_meta;
    logic       rx_sync;
    logic       rx_prev;
    logic       active;
    logic       fall;
    // two-entry tx bit buffer
    logic [BUF_DEPTH-1:0] buf_data;
    logic [1:0]           buf_cnt;
    logic [1:0]           next_buf_cnt;
    logic [BUF_DEPTH-1:0] next_buf_data;
    logic                 buf_pop;
    logic                 tx_busy;
    logic                 next_tx_busy;
    logic                 tx_bit;
    logic                 next_tx_bit;
    logic [3:0]           tx_cnt;
    logic [3:0]           next_tx_cnt;
    logic                 infrared_modulated_out;
    logic                 next_mod;
    // receive side
    rx_state_e            rx_state;
    rx_state_e            next_rx_state;
    logic [3:0]           rx_cnt;
    logic [3:0]           next_rx_cnt;
    logic                 rx_decoded;
    logic                 next_rx_decoded;
    logic                 rx_pending;
    logic                 next_rx_pending;

    // pin is asynchronous: two flops before use
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
            rx_prev <= 1'b0;
        end
        else
        begin
            rx_meta <= INFRARED_PULSE_IN;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    assign active = INFRARED_ENDEC_ENABLE_IN && UART_ENABLE_IN; // see [R8]
    // transceiver output is active high; pulse end seen as falling edge
    assign fall   = rx_prev && !rx_sync;

    assign UART_TX_READY_OUT = (buf_cnt != 2'(BUF_DEPTH));
    // pop on the last tick too, so back-to-back symbols stay exactly 16 ticks apart
    assign buf_pop = (buf_cnt != 2'h0) && BAUD_TICK_IN && (!tx_busy || tx_cnt == CNT_MAX); // see [R1] [R16]

    always_comb
    begin
        next_buf_cnt  = buf_cnt;
        next_buf_data = buf_data;
        next_tx_busy  = tx_busy;
        next_tx_bit   = tx_bit;
        next_tx_cnt   = tx_cnt;
        next_mod      = infrared_modulated_out;
        if (!active)
        begin
            next_buf_cnt = 2'h0;
            next_tx_busy = 1'b0;
            next_tx_cnt  = 4'h0;
            next_mod     = 1'b0;
        end
        else
        begin
            if (buf_pop)
            begin
                next_tx_bit   = buf_data[0];
                next_buf_data = {1'b0, buf_data[1]};
                next_buf_cnt  = buf_cnt - 2'h1;
                next_tx_busy  = 1'b1;
                next_tx_cnt   = 4'h0;
                // see [R3]: zero starts low for 7 ticks
                next_mod      = 1'b0;
            end
            else if (tx_busy && BAUD_TICK_IN) // see [R7]
            begin
                next_tx_cnt = tx_cnt + 4'h1;
                if (tx_cnt == CNT_MAX) // see [R1]
                begin
                    next_tx_busy = 1'b0;
                    next_mod     = 1'b0;
                end
                else
                begin
                    // see [R2] [R3]
                    next_mod = !tx_bit && (tx_cnt + 4'h1 >= TX_PULSE_START)
                               && (tx_cnt + 4'h1 < TX_PULSE_END);
                end
            end
            if (UART_TX_VALID_IN && UART_TX_READY_OUT)
            begin
                next_buf_data[next_buf_cnt[0]] = UART_TXD_IN;
                next_buf_cnt = next_buf_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            buf_cnt                <= 2'h0;
            buf_data               <= '0;
            tx_busy                <= 1'b0;
            tx_bit                 <= UART_IDLE_LEVEL;
            tx_cnt                 <= 4'h0;
            infrared_modulated_out <= 1'b0;
        end
        else
        begin
            buf_cnt                <= next_buf_cnt;
            buf_data               <= next_buf_data;
            tx_busy                <= next_tx_busy;
            tx_bit                 <= next_tx_bit;
            tx_cnt                 <= next_tx_cnt;
            infrared_modulated_out <= next_mod;
        end
    end

    // decoder; receive ignored while transmitting, half duplex
    always_comb
    begin
        next_rx_state   = rx_state;
        next_rx_cnt     = rx_cnt;
        next_rx_decoded = rx_decoded;
        next_rx_pending = rx_pending;
        if (!active || tx_busy) // see [R4]
        begin
            next_rx_state   = RX_IDLE;
            next_rx_cnt     = 4'h0;
            next_rx_decoded = UART_IDLE_LEVEL;
            next_rx_pending = 1'b0;
        end
        else
        begin
            case (rx_state)
                RX_IDLE:
                begin
                    if (fall)
                    begin
                        next_rx_cnt     = 4'h0; // see [R11]
                        next_rx_pending = 1'b1;
                        next_rx_state   = RX_FIRST;
                    end
                end
                RX_FIRST, RX_WINDOW:
                begin
                    if (fall && rx_state == RX_WINDOW)
                    begin
                        // see [R11] [R14]: pulse in window restarts cycle
                        next_rx_cnt     = 4'h0;
                        next_rx_pending = 1'b1;
                        next_rx_state   = RX_FIRST;
                    end
                    else if (BAUD_TICK_IN)
                    begin
                        next_rx_cnt = rx_cnt + 4'h1; // see [R9]
                        if (rx_cnt + 4'h1 == RX_UPDATE_CNT) // see [R12] [R10]
                        begin
                            next_rx_decoded = !rx_pending;
                            next_rx_pending = 1'b0;
                            // see [R13] [R14]: window closing with no pulse
                            if (rx_state == RX_WINDOW && !rx_pending)
                                next_rx_state = RX_IDLE;
                        end
                        if (rx_cnt + 4'h1 == RX_WINDOW_OPEN) // see [R13]
                            next_rx_state = RX_WINDOW;
                    end
                end
                default:
                    next_rx_state = RX_IDLE;
            endcase
        end
    end

    // idle return comes with the decoded one of that count 8; idle then holds it
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rx_state   <= RX_IDLE;
            rx_cnt     <= 4'h0;
            rx_decoded <= UART_IDLE_LEVEL;
            rx_pending <= 1'b0;
        end
        else
        begin
            rx_state   <= next_rx_state;
            rx_cnt     <= next_rx_cnt;
            rx_decoded <= next_rx_decoded;
            rx_pending <= next_rx_pending;
        end
    end

    // output mux; UART's own start-bit search untouched, see [R15]
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            TXD_PIN_OUT  <= UART_IDLE_LEVEL;
            UART_RXD_OUT <= UART_IDLE_LEVEL;
        end
        else
        begin
            TXD_PIN_OUT  <= INFRARED_ENDEC_ENABLE_IN ? infrared_modulated_out : UART_TXD_IN; // see [R5] [R19]
            UART_RXD_OUT <= INFRARED_ENDEC_ENABLE_IN ? rx_decoded : rx_sync;                  // see [R6] [R19]
        end
    end

    a_tx_one_low: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R2]
        tx_busy && tx_bit |-> !infrared_modulated_out) else $error("one symbol pulsed");
    a_tx_pulse_pos: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R3]
        infrared_modulated_out |-> tx_busy && !tx_bit && tx_cnt >= TX_PULSE_START
        && tx_cnt < TX_PULSE_END) else $error("pulse outside ticks 7..9");
    a_tx_pulse_rise: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R3]
        $rose(infrared_modulated_out) |-> tx_cnt == TX_PULSE_START) else $error("pulse rose off tick 7");
    a_tx_pulse_fall: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R3]
        $fell(infrared_modulated_out) && active |-> tx_cnt == TX_PULSE_END) else $error("pulse not 3 ticks");
    a_tx_zero_start: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R3]
        buf_pop && active |=> tx_busy && tx_cnt == 4'h0 && !infrared_modulated_out)
        else $error("symbol did not start low");
    // a waiting bit must start at once, else the bit period stretches
    a_tx_symbol_len: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R1]
        tx_busy && tx_cnt == CNT_MAX && BAUD_TICK_IN && active |=> tx_cnt == 4'h0 && tx_busy == $past(buf_pop))
        else $error("symbol not 16 ticks");
    a_half_duplex: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R4]
        tx_busy |=> rx_state == RX_IDLE) else $error("receive during transmit");
    a_pin_route: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R5]
        INFRARED_ENDEC_ENABLE_IN |=> TXD_PIN_OUT == $past(infrared_modulated_out))
        else $error("pin not fed by encoder");
    a_rx_route: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R19]
        !INFRARED_ENDEC_ENABLE_IN |=> UART_RXD_OUT == $past(rx_sync))
        else $error("bypass not straight");
    a_disabled_idle: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R8]
        !UART_ENABLE_IN |=> !tx_busy && rx_state == RX_IDLE) else $error("active without UART");
    a_fall_resync: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R11]
        fall && active && !tx_busy && rx_state != RX_FIRST |=> rx_cnt == 4'h0 && rx_pending)
        else $error("edge did not resync");
    a_update_at8: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R12]
        $changed(rx_decoded) && active && !$past(tx_busy) |-> rx_cnt == RX_UPDATE_CNT)
        else $error("decoded changed off count 8");
    a_window_open: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R13]
        rx_state == RX_WINDOW |-> rx_cnt >= RX_WINDOW_OPEN || rx_cnt <= RX_UPDATE_CNT)
        else $error("window outside 12..8");
    a_rxd_route_on: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R6]
        INFRARED_ENDEC_ENABLE_IN |=> UART_RXD_OUT == $past(rx_decoded))
        else $error("UART input not fed by decoder");
    // decoder steps: the tick that takes the count to 8, then the update
    sequence s_rx_before_update;
        BAUD_TICK_IN && rx_cnt == RX_UPDATE_CNT - 4'h1 && active && !tx_busy && !fall;
    endsequence
    a_rx_zero_out: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R12]
        (s_rx_before_update ##0 rx_state == RX_FIRST) |=> !rx_decoded) else $error("pulse not decoded as zero");
    a_rx_lag_out: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R10]
        (s_rx_before_update ##0 rx_state == RX_FIRST && INFRARED_ENDEC_ENABLE_IN) |=> ##1 !UART_RXD_OUT)
        else $error("zero not passed on 8 ticks after pulse");
    a_rx_one_idle: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) // see [R14]
        (s_rx_before_update ##0 rx_state == RX_WINDOW) |=> rx_state == RX_IDLE && rx_decoded)
        else $error("empty window did not return to idle");
endmodule : infrared_pulse_endec
`default_nettype wire

/* hw/irda_endec_pkg.sv */
// constants shared by the infrared pulse encoder/decoder
package irda_endec_pkg;
    localparam int unsigned TICKS_PER_BIT   = 16;
    localparam logic [3:0]  CNT_MAX         = 4'hf;
    localparam logic [3:0]  TX_PULSE_START  = 4'h7;   // after 7 low ticks
    localparam logic [3:0]  TX_PULSE_END    = 4'ha;   // 3 high ticks, then 6 low
    localparam logic [3:0]  RX_UPDATE_CNT   = 4'h8;
    localparam logic [3:0]  RX_WINDOW_OPEN  = 4'hc;
    localparam logic        UART_IDLE_LEVEL = 1'b1;
    localparam int unsigned BUF_DEPTH       = 2;
    typedef enum logic [2:0]
    {
        RX_IDLE   = 3'b001,
        RX_FIRST  = 3'b010,   // pulse seen, before window opens
        RX_WINDOW = 3'b100    // sampling window open
    } rx_state_e;
endpackage : irda_endec_pkg

/* sim/infrared_pulse_endec_tb_top.sv */
// self-checking bench for the infrared pulse endec
`timescale 1ns/1ns
`default_nettype none
module infrared_pulse_endec_tb_top;
    import irda_endec_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic uen = 1'b0;
    logic ien = 1'b0;
    logic txd = 1'b1;
    logic tvld = 1'b0;
    logic flip = 1'b0;
    logic tick, pulse, rdy, rxd, pin;
    logic sawfull = 1'b0;
    logic q[$];
    logic [15:0] bits;
    int bad_count = 0;
    int samples_checked = 0;
    always #4 clk = ~clk; // 125 MHz, far above the 1 MHz floor
    ir_xcvr_model #(.TICK_DIV(6)) xcvr (.clk_in(clk), .tick_out(tick), .pulse_out(pulse));
    infrared_pulse_endec dut
    (
        .CLK_SYS_IN              (clk),
        .RESETN_IN               (rstn),
        .BAUD_TICK_IN            (tick),
        .UART_ENABLE_IN          (uen),
        .INFRARED_ENDEC_ENABLE_IN(ien),
        .UART_TXD_IN             (txd),
        .UART_TX_VALID_IN        (tvld),
        .UART_TX_READY_OUT       (rdy),
        .UART_RXD_OUT            (rxd),
        .TXD_PIN_OUT             (pin),
        .INFRARED_PULSE_IN       (pulse ^ flip)
    );
    always @(posedge clk)
        if (tick)
            q.push_back(pin);
    task automatic chk(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic ticks(input int n);
        repeat (n) @(posedge clk iff tick);
    endtask : ticks
    task automatic push(input logic b);
        int i;
        i = 0;
        @(negedge clk);
        txd = b;
        tvld = 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1 && i < 400)
        begin
            sawfull = 1'b1;
            i++;
            @(posedge clk);
        end
        if (i == 400)
        begin
            bad_count++;
            end_of_test();
        end
        @(negedge clk);
        tvld = 1'b0;
    endtask : push
    // pulses arriving while the decoder must stay deaf
    task automatic rx_quiet(input int n);
        int lows;
        lows = 0;
        fork
            xcvr.send_bits(16'h0000, n);
            for (int i = 0; i < 16 * n + 12; i++)
            begin
                ticks(1);
                lows += (rxd !== 1'b1);
            end
        join
        chk(lows == 0, 1'b1, "receive not ignored");
    endtask : rx_quiet
    initial
    begin
        repeat (90000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
    initial
    begin
        int i0;
        void'($urandom(77090));
        repeat (5) @(posedge clk);
        chk(pin, 1'b1, "pin reset");
        chk(rxd, UART_IDLE_LEVEL, "rxd reset");
        chk(rdy, 1'b1, "ready reset");
        @(negedge clk);
        rstn = 1'b1;
        uen = 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            txd = 1'($urandom);
            flip = 1'($urandom);
            repeat (4) @(negedge clk);
            chk(pin, txd, "tx bypass");
            chk(rxd, flip, "rx bypass");
        end
        flip = 1'b0;
        ien = 1'b1; // enabled ahead of any encoder pin use
        repeat (20) @(negedge clk);
        bits = 16'($urandom);
        bits[0] = 1'b0;
        q.delete();
        for (int k = 0; k < 6; k++)
            push(bits[k]);
        ticks(16 * 6 + 20);
        i0 = 0;
        while (i0 < q.size() - 96 && q[i0] !== 1'b1)
            i0++;
        for (int k = 0; k < 96; k++)
            chk(q[i0 + k], !bits[k / 16] && k % 16 < 3, "symbol shape");
        chk(sawfull, 1'b1, "buffer never full");
        // corner: zero, run of ones to idle, then back-to-back zeros
        bits = 16'($urandom);
        bits[3:0] = 4'he;
        bits[6:5] = 2'b00;
        fork
            xcvr.send_bits(bits, 8);
            begin
                ticks(1);
                ticks(26);
                for (int k = 0; k < 8; k++)
                begin
                    chk(rxd, bits[k], "decoded bit");
                    ticks(16);
                end
            end
        join
        push(1'b0);
        push(1'b0);
        rx_quiet(2);
        ticks(40);
        @(negedge clk);
        uen = 1'b0;
        rx_quiet(2);
        end_of_test();
    end
endmodule : infrared_pulse_endec_tb_top
`default_nettype wire

/* sim/ir_xcvr_model.sv */
// infrared transceiver model and baud tick source
`timescale 1ns/1ns
`default_nettype none
module ir_xcvr_model
#(
    parameter int TICK_DIV = 6
)
(
    input  wire logic clk_in,    // system clock
    output logic      tick_out,  // baud tick
    output logic      pulse_out  // light pulse, active high
);
    int div = 0;
    initial pulse_out = 1'b0;
    always @(negedge clk_in)
    begin
        div = (div + 1) % TICK_DIV;
        tick_out = (div == 0);
    end
    // zero: pulse over ticks 7..9; dark between frames
    task automatic send_bits(input logic [15:0] b, input int n);
        for (int k = 0; k < n; k++)
        begin
            for (int t = 0; t < 16; t++)
            begin
                @(posedge clk_in iff tick_out);
                @(negedge clk_in);
                pulse_out <= !b[k] && t >= 7 && t <= 9;
            end
        end
        @(posedge clk_in iff tick_out);
        @(negedge clk_in);
        pulse_out <= 1'b0;
    endtask : send_bits
endmodule : ir_xcvr_model
`default_nettype wire
